// File: include/fesr_defs.vh
// Constants for the flash erase and suspend/resume sequencer
`ifndef FESR_DEFS_VH
`define FESR_DEFS_VH
`define FESR_CLK_NS 10
`define FESR_SSE_US 50
`define FESR_SE_US 150
`define FESR_DIE_US 400
`define FESR_PP_US 20
`define FESR_SUS_US 5
`define FESR_OP_WREN 8'h06
`define FESR_OP_WRDI 8'h04
`define FESR_OP_RDSR 8'h05
`define FESR_OP_RDFS 8'h70
`define FESR_OP_CLFS 8'h50
`define FESR_OP_READ 8'h03
`define FESR_OP_PROG 8'h02
`define FESR_OP_SSE 8'h20
`define FESR_OP_SE 8'hD8
`define FESR_OP_DIE 8'hC4
`define FESR_OP_SUS 8'h75
`define FESR_OP_RES 8'h7A
`define FESR_FS_RST 8'h80
`define FESR_FS_RDY 7
`define FESR_FS_ESUS 6
`define FESR_FS_EERR 5
`define FESR_FS_PERR 4
`define FESR_FS_PSUS 2
`define FESR_FS_PROT 1
`define FESR_SR_WIP 0
`define FESR_SR_WEL 1
`define FESR_ACT_NONE 2'h0
`define FESR_ACT_ERS 2'h1
`define FESR_ACT_PRG 2'h2
`define FESR_KIND_SUB 2'h0
`define FESR_KIND_SEC 2'h1
`define FESR_KIND_DIE 2'h2
`define FESR_ADDR_BITS 32
`define FESR_SUB_LSB 12
`define FESR_SEC_LSB 16
`define FESR_PAGE_LSB 8
`endif

// File: core/fesr_core.v
// Erase, program timing and suspend/resume sequencer behind the serial pins
`include "fesr_defs.vh"
module fesr_core #(
    parameter SSE_CYC = `FESR_SSE_US * 1000 / `FESR_CLK_NS,
    parameter SE_CYC = `FESR_SE_US * 1000 / `FESR_CLK_NS,
    parameter DIE_CYC = `FESR_DIE_US * 1000 / `FESR_CLK_NS,
    parameter PP_CYC = `FESR_PP_US * 1000 / `FESR_CLK_NS,
    parameter SUS_CYC = `FESR_SUS_US * 1000 / `FESR_CLK_NS
) (
    input wire ref_clk,
    input wire rstn,
    input wire cs_n,
    input wire sclk,
    input wire serial_data_lines,
    output reg sdo,
    output reg sdo_oe,
    input wire addr_protected,
    input wire any_locked,
    input wire arr_fault,
    output wire [31:0] cmd_addr,
    output reg ers_go,
    output reg [1:0] ers_kind,
    output reg [31:0] ers_base,
    output reg prg_go,
    output reg [31:0] prg_addr,
    output reg arr_hold,
    output reg rd_undef,
    output wire [7:0] status,
    output wire [7:0] flag_status
);
    localparam [31:0] SSE_C = SSE_CYC;
    localparam [31:0] SE_C = SE_CYC;
    localparam [31:0] DIE_C = DIE_CYC;
    localparam [31:0] PP_C = PP_CYC;
    localparam [31:0] SUS_C = SUS_CYC;

    function [31:0] base_of;
        input [31:0] a;
        input [1:0] k;
        begin
            if (k == `FESR_KIND_SUB)
                base_of = {a[31:`FESR_SUB_LSB], {`FESR_SUB_LSB{1'b0}}};
            else if (k == `FESR_KIND_SEC)
                base_of = {a[31:`FESR_SEC_LSB], {`FESR_SEC_LSB{1'b0}}};
            else
                base_of = 32'h00000000;
        end
    endfunction

    function same_sec;
        input [31:0] a;
        input [31:0] b;
        begin
            same_sec = a[31:`FESR_SEC_LSB] == b[31:`FESR_SEC_LSB];
        end
    endfunction

    // Pin synchronisers
    reg [1:0] cs_s_r;
    reg [1:0] ck_s_r;
    reg [1:0] di_s_r;
    reg ck_d_r;
    reg cs_d_r;
    always @(posedge ref_clk) begin
        if (!rstn) begin
            cs_s_r <= 2'h3;
            ck_s_r <= 2'h0;
            di_s_r <= 2'h0;
            ck_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else begin
            cs_s_r <= {cs_s_r[0], cs_n};
            ck_s_r <= {ck_s_r[0], sclk};
            di_s_r <= {di_s_r[0], serial_data_lines};
            ck_d_r <= ck_s_r[1];
            cs_d_r <= cs_s_r[1];
        end
    end
    wire sel = !cs_s_r[1];
    wire ck_rise = sel && ck_s_r[1] && !ck_d_r;
    wire ck_fall = sel && !ck_s_r[1] && ck_d_r;
    wire cs_rise = cs_s_r[1] && !cs_d_r;

    // Command shifter
    reg [11:0] bits_r;
    reg [7:0] op_r;
    reg [7:0] sh_r;
    reg [31:0] addr_r;
    reg [7:0] osh_r;
    wire [7:0] sh_nxt = {sh_r[6:0], di_s_r[1]};
    assign cmd_addr = addr_r;

    // Operation state
    reg wel_r;
    reg [7:0] fs_r;
    reg [1:0] act_r;
    reg [31:0] cnt_r;
    reg [31:0] lat_r;
    reg lat_on_r;
    reg ers_sus_r;
    reg prg_sus_r;
    reg [31:0] ers_sav_r;
    reg [31:0] prg_sav_r;
    reg [31:0] ers_adr_r;
    reg [31:0] prg_adr_r;
    reg [1:0] cur_kind_r;

    wire busy = act_r != `FESR_ACT_NONE;
    assign status = {6'h00, wel_r, busy};
    assign flag_status = {!busy, fs_r[6:0]};

    wire aligned = bits_r[2:0] == 3'h0;
    wire full_addr = bits_r == 12'd40;
    wire suspended = ers_sus_r || prg_sus_r;
    wire done = busy && cnt_r == 32'h00000001;
    wire [1:0] e_kind = (op_r == `FESR_OP_SSE) ? `FESR_KIND_SUB :
        (op_r == `FESR_OP_SE) ? `FESR_KIND_SEC : `FESR_KIND_DIE;
    wire is_erase = op_r == `FESR_OP_SSE || op_r == `FESR_OP_SE ||
        op_r == `FESR_OP_DIE;
    wire e_len_ok = (op_r == `FESR_OP_DIE) ? bits_r == 12'd8 : full_addr;

    always @(posedge ref_clk) begin
        if (!rstn) begin
            bits_r <= 12'h000;
            op_r <= 8'h00;
            sh_r <= 8'h00;
            addr_r <= 32'h00000000;
            osh_r <= 8'h00;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
            rd_undef <= 1'b0;
        end else begin
            if (!sel) begin
                bits_r <= 12'h000;
                sdo_oe <= 1'b0;
            end
            if (ck_rise) begin
                sh_r <= sh_nxt;
                if (bits_r != 12'hFFF)
                    bits_r <= bits_r + 12'h001;
                if (bits_r == 12'd7)
                    op_r <= sh_nxt;
                if (bits_r >= 12'd8 && bits_r < 12'd40)
                    addr_r <= {addr_r[30:0], di_s_r[1]};
                if (bits_r == 12'd39 && op_r == `FESR_OP_READ)
                    rd_undef <= (prg_sus_r &&
                        prg_adr_r[31:`FESR_PAGE_LSB] == addr_r[30:7]) ||
                        (ers_sus_r && same_sec(ers_adr_r, {addr_r[30:0], di_s_r[1]}));
            end
            if (ck_fall && bits_r >= 12'd8 &&
                (op_r == `FESR_OP_RDSR || op_r == `FESR_OP_RDFS)) begin
                sdo_oe <= 1'b1;
                if (bits_r[2:0] == 3'h0) begin
                    osh_r <= (op_r == `FESR_OP_RDSR) ? status : flag_status;
                    sdo <= (op_r == `FESR_OP_RDSR) ? status[7] : flag_status[7];
                end else begin
                    osh_r <= {osh_r[6:0], 1'b0};
                    sdo <= osh_r[6];
                end
            end
        end
    end

    // Command execution at select rise, and the self-timed engine
    always @(posedge ref_clk) begin
        if (!rstn) begin
            wel_r <= 1'b0;
            fs_r <= `FESR_FS_RST;
            act_r <= `FESR_ACT_NONE;
            cnt_r <= 32'h00000000;
            lat_r <= 32'h00000000;
            lat_on_r <= 1'b0;
            ers_sus_r <= 1'b0;
            prg_sus_r <= 1'b0;
            ers_sav_r <= 32'h00000000;
            prg_sav_r <= 32'h00000000;
            ers_adr_r <= 32'h00000000;
            prg_adr_r <= 32'h00000000;
            cur_kind_r <= `FESR_KIND_SUB;
            ers_go <= 1'b0;
            ers_kind <= `FESR_KIND_SUB;
            ers_base <= 32'h00000000;
            prg_go <= 1'b0;
            prg_addr <= 32'h00000000;
            arr_hold <= 1'b0;
        end else begin
            ers_go <= 1'b0;
            prg_go <= 1'b0;
            if (busy)
                cnt_r <= cnt_r - 32'h00000001;
            if (lat_on_r && !done) begin
                lat_r <= lat_r - 32'h00000001;
                if (lat_r == 32'h00000001) begin
                    lat_on_r <= 1'b0;
                    act_r <= `FESR_ACT_NONE;
                    arr_hold <= 1'b1;
                    if (act_r == `FESR_ACT_ERS) begin
                        ers_sus_r <= 1'b1;
                        ers_sav_r <= cnt_r - 32'h00000001;
                    end else begin
                        prg_sus_r <= 1'b1;
                        prg_sav_r <= cnt_r - 32'h00000001;
                    end
                end
            end
            if (done) begin
                act_r <= `FESR_ACT_NONE;
                wel_r <= 1'b0;
                arr_hold <= 1'b0;
                if (lat_on_r) begin
                    lat_on_r <= 1'b0;
                    if (act_r == `FESR_ACT_ERS)
                        fs_r[`FESR_FS_ESUS] <= 1'b0;
                    else
                        fs_r[`FESR_FS_PSUS] <= 1'b0;
                end
                if (arr_fault && act_r == `FESR_ACT_ERS)
                    fs_r[`FESR_FS_EERR] <= 1'b1;
                if (arr_fault && act_r == `FESR_ACT_PRG)
                    fs_r[`FESR_FS_PERR] <= 1'b1;
                if (ers_sus_r)
                    arr_hold <= 1'b1;
            end
            if (cs_rise && aligned && bits_r != 12'h000) begin
                if (op_r == `FESR_OP_WREN && bits_r == 12'd8)
                    wel_r <= 1'b1;
                if (op_r == `FESR_OP_WRDI && bits_r == 12'd8 && !busy)
                    wel_r <= 1'b0;
                if (op_r == `FESR_OP_CLFS && bits_r == 12'd8)
                    // Error bits cleared; a fault ending now still sets
                    fs_r[5:1] <= {done && arr_fault && act_r == `FESR_ACT_ERS,
                        done && arr_fault && act_r == `FESR_ACT_PRG, fs_r[3],
                        fs_r[2] && !(done && lat_on_r && act_r == `FESR_ACT_PRG), 1'b0};
                // Erase: latch set, idle, nothing suspended
                if (is_erase && e_len_ok && wel_r && !busy && !suspended) begin
                    if ((op_r == `FESR_OP_DIE && any_locked) ||
                        (op_r != `FESR_OP_DIE && addr_protected)) begin
                        fs_r[`FESR_FS_PROT] <= 1'b1;
                        fs_r[`FESR_FS_EERR] <= 1'b1;
                    end else begin
                        act_r <= `FESR_ACT_ERS;
                        cur_kind_r <= e_kind;
                        cnt_r <= (e_kind == `FESR_KIND_SUB) ? SSE_C :
                            (e_kind == `FESR_KIND_SEC) ? SE_C : DIE_C;
                        ers_adr_r <= addr_r;
                        ers_go <= 1'b1;
                        ers_kind <= e_kind;
                        ers_base <= base_of(addr_r, e_kind);
                    end
                end
                if (op_r == `FESR_OP_PROG && bits_r >= 12'd48 && wel_r &&
                    !busy && !prg_sus_r) begin
                    if (ers_sus_r && same_sec(addr_r, ers_adr_r))
                        fs_r[`FESR_FS_PERR] <= 1'b1;
                    else begin
                        act_r <= `FESR_ACT_PRG;
                        cnt_r <= PP_C;
                        prg_adr_r <= addr_r;
                        prg_go <= 1'b1;
                        prg_addr <= addr_r;
                        arr_hold <= 1'b0;
                    end
                end
                if (op_r == `FESR_OP_SUS && bits_r == 12'd8 && busy &&
                    !lat_on_r && !done) begin
                    lat_on_r <= 1'b1;
                    lat_r <= SUS_C;
                    if (act_r == `FESR_ACT_ERS)
                        fs_r[`FESR_FS_ESUS] <= 1'b1;
                    else
                        fs_r[`FESR_FS_PSUS] <= 1'b1;
                end
                if (op_r == `FESR_OP_RES && bits_r == 12'd8 && !busy) begin
                    if (prg_sus_r) begin
                        prg_sus_r <= 1'b0;
                        act_r <= `FESR_ACT_PRG;
                        cnt_r <= prg_sav_r;
                        fs_r[`FESR_FS_PSUS] <= 1'b0;
                        arr_hold <= 1'b0;
                    end else if (ers_sus_r) begin
                        ers_sus_r <= 1'b0;
                        act_r <= `FESR_ACT_ERS;
                        cnt_r <= ers_sav_r;
                        fs_r[`FESR_FS_ESUS] <= 1'b0;
                        arr_hold <= 1'b0;
                    end
                end
            end
        end
    end
endmodule

// File: verif/fesr_core_asserts.sv
// Port checks for the erase and suspend/resume sequencer
module fesr_chk #(
    parameter int DIE_CYC = 1,
    parameter int SUS_CYC = 1
) (
    input logic ref_clk,
    input logic rstn,
    input logic ers_go,
    input logic [1:0] ers_kind,
    input logic [31:0] ers_base,
    input logic arr_hold,
    input logic [7:0] status,
    input logic [7:0] flag_status
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    int busy_r;
    always @(posedge ref_clk) begin
        busy_r <= (!rstn || !status[0]) ? 0 : busy_r + 1;
    end
    sequence s_launch;
        ers_go ##1 !ers_go;
    endsequence
    sequence s_held;
        flag_status[7] && (flag_status[6] || flag_status[2]);
    endsequence
    AST_GO_PULSE: assert property (ers_go |-> s_launch)
        else $error("erase start not one cycle");
    AST_GO_BUSY: assert property (ers_go |-> status[0] && !flag_status[7])
        else $error("busy bits wrong at erase start");
    AST_GO_WEL: assert property (ers_go |-> $past(status[1]))
        else $error("erase started without write enable");
    AST_SUB_BASE: assert property (ers_go && ers_kind == 2'h0 |-> ers_base[11:0] == 12'h000)
        else $error("subsector base not aligned");
    AST_SEC_BASE: assert property (ers_go && ers_kind == 2'h1 |-> ers_base[15:0] == 16'h0000)
        else $error("sector base not aligned");
    AST_WEL_CLR: assert property ($fell(status[0]) |-> ##1
        (!status[1] || arr_hold || flag_status[6] || flag_status[2]))
        else $error("write enable kept after completion");
    AST_WIP_RDY: assert property (status[0] && !arr_hold |-> !flag_status[7])
        else $error("ready bit high while busy");
    AST_HOLD_FLAGS: assert property ($rose(arr_hold) |-> ##[0:1] s_held)
        else $error("suspended without ready and suspend bits");
    AST_BUSY_MAX: assert property (busy_r <= DIE_CYC + SUS_CYC + 4)
        else $error("operation runs too long");
    AST_RST_FLAGS: assert property ($rose(rstn) |-> flag_status == 8'h80 && status == 8'h00)
        else $error("wrong values after reset");
endmodule
bind fesr_core fesr_chk #(.DIE_CYC(DIE_CYC), .SUS_CYC(SUS_CYC)) u_chk (
    .ref_clk, .rstn, .ers_go, .ers_kind, .ers_base, .arr_hold, .status, .flag_status
);

// File: verif/fesr_host.sv
// Host serial controller model: select, clock and data lines
module fesr_host (
    input logic ref_clk,
    input logic sdo,
    output logic cs_n,
    output logic sclk,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // Low half 5 or 6 cycles, high half 7: 125 ns on average
    task automatic xfer(input logic [63:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge ref_clk) cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk) sdi <= w[63 - i];
            repeat (3 + i % 2) @(posedge ref_clk);
            @(posedge ref_clk) sclk <= 1'b1;
            if (i >= n - 8) rd = {rd[6:0], sdo};
            repeat (6) @(posedge ref_clk);
            @(posedge ref_clk) sclk <= 1'b0;
        end
        repeat (2) @(posedge ref_clk);
        // Select rises after the n bits asked for, whether or not n is a whole number of bytes
        @(posedge ref_clk) cs_n <= 1'b1;
        sdi <= ~sdi;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

// File: verif/test_flash_erase_suspend_resume.sv
// Self-checking bench for the erase and suspend/resume sequencer
`include "fesr_defs.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); n_fail++; end end
module test_flash_erase_suspend_resume;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SSE = 600, SE = 700, DIE = 800, PP = 500, SUS = 150;
    logic ref_clk = 0, rstn = 0, addr_protected = 0, any_locked = 0, arr_fault = 0;
    logic cs_n, sclk, sdi, sdo, sdo_oe, ers_go, prg_go, arr_hold, rd_undef;
    logic [1:0] ers_kind, go_kind;
    logic [31:0] cmd_addr, ers_base, prg_addr, go_base;
    logic [7:0] status, flag_status, rd;
    int n_fail = 0, n_checks = 0, seed = 11475, cyc = 0, t_go = 0, n_go = 0;
    fesr_core #(.SSE_CYC(SSE), .SE_CYC(SE), .DIE_CYC(DIE), .PP_CYC(PP), .SUS_CYC(SUS)) dut (
        .ref_clk, .rstn, .cs_n, .sclk, .serial_data_lines(sdi), .sdo, .sdo_oe,
        .addr_protected, .any_locked, .arr_fault, .cmd_addr, .ers_go, .ers_kind,
        .ers_base, .prg_go, .prg_addr, .arr_hold, .rd_undef, .status, .flag_status);
    fesr_host host (.ref_clk, .sdo, .cs_n, .sclk, .sdi);
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (ers_go === 1'b1) begin
            n_go++;
            t_go = cyc;
            go_kind = ers_kind;
            go_base = ers_base;
            `CHK("go busy", 2'b01, {flag_status[7], status[0]})
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int n);
        host.xfer({op, a, 24'h0}, n, rd);
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 5000 && status[0] !== 1'b0; k++) @(posedge ref_clk);
        if (k == 5000) begin
            $display("[FAIL] idle wait timed out");
            n_fail++;
            stop_test();
        end
    endtask
    initial begin
        int g, p;
        logic [31:0] a;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        `CHK("status", 8'h00, status)
        `CHK("flags", 8'h80, flag_status)
        g = n_go;
        cmd(`FESR_OP_SSE, 0, 40);
        `CHK("no wel", g, n_go)
        `CHK("no wel flags", 8'h80, flag_status)
        cmd(`FESR_OP_WREN, 0, 8);
        cmd(`FESR_OP_SSE, 0, 37);
        `CHK("odd bits", g, n_go)
        `CHK("odd status", 8'h02, status)
        `CHK("odd flags", 8'h80, flag_status)
        for (int k = 0; k < 3; k++) begin
            a = $random(seed);
            cmd(`FESR_OP_WREN, 0, 8);
            cmd(k == 0 ? `FESR_OP_SSE : k == 1 ? `FESR_OP_SE : `FESR_OP_DIE, a, k == 2 ? 8 : 40);
            `CHK("kind", k[1:0], go_kind)
            if (k < 2) `CHK("base", k ? {a[31:16], 16'h0} : {a[31:12], 12'h0}, go_base)
            wait_idle();
            p = k == 0 ? SSE : k == 1 ? SE : DIE;
            `CHK("time", 1'b1, cyc - t_go >= p - 2 && cyc - t_go <= p + 2)
            `CHK("done status", 8'h00, status)
            `CHK("done flags", 8'h80, flag_status)
        end
        for (int k = 0; k < 3; k++) begin
            cmd(`FESR_OP_CLFS, 0, 8);
            cmd(`FESR_OP_WREN, 0, 8);
            addr_protected <= k == 0;
            any_locked <= k == 1;
            arr_fault <= k == 2;
            g = n_go;
            cmd(k == 1 ? `FESR_OP_DIE : `FESR_OP_SSE, $random(seed), k == 1 ? 8 : 40);
            wait_idle();
            `CHK("refused", k == 2 ? g + 1 : g, n_go)
            `CHK("wel", k == 2 ? 8'h00 : 8'h02, status)
            `CHK("err flags", k == 2 ? 8'hA0 : 8'hA2, flag_status)
        end
        addr_protected <= 1'b0;
        any_locked <= 1'b0;
        arr_fault <= 1'b0;
        cmd(`FESR_OP_CLFS, 0, 8);
        cmd(`FESR_OP_WREN, 0, 8);
        cmd(`FESR_OP_SE, 32'h0003_0000, 40);
        cmd(`FESR_OP_SUS, 0, 8);
        `CHK("erase susp", 1'b1, flag_status[6])
        repeat (SUS) @(posedge ref_clk);
        `CHK("held", 1'b1, arr_hold)
        cmd(`FESR_OP_RDFS, 0, 16);
        `CHK("read flags", 8'hC0, rd)
        cmd(`FESR_OP_WREN, 0, 8);
        cmd(`FESR_OP_PROG, 32'h0003_1200, 48);
        `CHK("prog refused", 8'hD0, flag_status)
        `CHK("wel kept", 1'b1, status[1])
        cmd(`FESR_OP_PROG, 32'h0005_0000, 48);
        `CHK("prog runs", 1'b1, status[0])
        cmd(`FESR_OP_SUS, 0, 8);
        repeat (SUS) @(posedge ref_clk);
        `CHK("nested", 3'b111, {flag_status[7:6], flag_status[2]})
        cmd(`FESR_OP_READ, 32'h0003_4000, 40);
        `CHK("undef read", 1'b1, rd_undef)
        cmd(`FESR_OP_READ, 32'h0007_0000, 40);
        `CHK("clean read", 1'b0, rd_undef)
        for (int k = 0; k < 2; k++) begin
            cmd(`FESR_OP_RES, 0, 8);
            `CHK("resumed", 2'b01, {flag_status[7], status[0]})
            wait_idle();
            `CHK("order", k ? 2'b10 : 2'b11, flag_status[7:6])
        end
        `CHK("final flags", 8'h90, flag_status)
        cmd(`FESR_OP_RES, 0, 8);
        `CHK("idle resume", 8'h00, status)
        cmd(`FESR_OP_CLFS, 0, 8);
        cmd(`FESR_OP_WREN, 0, 8);
        cmd(`FESR_OP_SSE, $random(seed), 40);
        repeat (SSE - 220) @(posedge ref_clk);
        cmd(`FESR_OP_SUS, 0, 8);
        wait_idle();
        `CHK("short tail", 8'h80, flag_status)
        `CHK("not held", 1'b0, arr_hold)
        stop_test();
    end
endmodule
